// ---- drc_pkg.sv ----
// Package: register map, field layout and reset values of the reference converter
package drc_pkg;

   // Register byte addresses on the APB (one aligned word each)
   localparam logic [11:0] DRC_OFF_CTRL_A   = 12'h000;
   localparam logic [11:0] DRC_OFF_LEVEL    = 12'h004;

   // Field positions in converter_control_a
   localparam int DRC_BIT_ENABLE    = 7;
   localparam int DRC_BIT_PIN_ONE   = 5;
   localparam int DRC_BIT_PIN_TWO   = 4;
   localparam int DRC_BIT_UPPER_HI  = 3;
   localparam int DRC_BIT_UPPER_LO  = 2;
   localparam int DRC_BIT_LOWER     = 0;

   // Writable masks; unimplemented bits stay zero
   localparam logic [7:0] DRC_MASK_CTRL_A = 8'hbd;
   localparam logic [7:0] DRC_MASK_LEVEL  = 8'h1f;

   // Reset values
   localparam logic [7:0] DRC_RST_CTRL_A = 8'h00;
   localparam logic [7:0] DRC_RST_LEVEL  = 8'h00;

   // Level count and code width
   localparam int DRC_LEVEL_W     = 5;
   localparam int DRC_LEVEL_COUNT = 32;

   // Positive source codes
   typedef enum logic [1:0] {
      DRC_UP_SUPPLY   = 2'h0,
      DRC_UP_EXT_PIN  = 2'h1,
      DRC_UP_FIXED    = 2'h2,
      DRC_UP_RESERVED = 2'h3
   } drc_upper_t;

   // Decode of a positive source code into one-hot selects
   function automatic logic [2:0] drc_upper_onehot(input logic [1:0] code);
      logic [2:0] sel;
      sel = 3'h0;
      unique case (code)
         DRC_UP_SUPPLY:  sel = 3'h1;
         DRC_UP_EXT_PIN: sel = 3'h2;
         DRC_UP_FIXED:   sel = 3'h4;
         default:        sel = 3'h0;
      endcase
      return sel;
   endfunction : drc_upper_onehot

endpackage : drc_pkg

// ---- drc_pin_ctrl.sv ----
// Pin override logic for one analog output pin
`timescale 1ns/1ps
module drc_pin_ctrl
   import drc_pkg::*;
(
   // Setting
   input  wire logic drive_en_i,      // Converter voltage routed to pin
   // Digital pad side
   input  wire logic pad_in_i,        // Raw digital input of the pad
   input  wire logic gpio_out_i,      // Digital port output value
   input  wire logic gpio_oe_i,       // Digital port output enable
   input  wire logic pullup_req_i,    // Pull-up requested by port logic
   // Results
   output logic      analog_sw_o,     // Analog switch to converter
   output logic      pad_out_o,       // Digital driver value
   output logic      pad_oe_o,        // Digital driver enable
   output logic      pullup_en_o,     // Weak pull-up enable
   output logic      gpio_read_o      // Value seen by a digital read
);

   // Overrides are pure gating, so they act in the cycle the setting changes
   always_comb begin
      analog_sw_o = drive_en_i;
      pad_out_o   = gpio_out_i & ~drive_en_i;
      pad_oe_o    = gpio_oe_i & ~drive_en_i;
      pullup_en_o = pullup_req_i & ~drive_en_i;
      gpio_read_o = pad_in_i & ~drive_en_i;
   end

endmodule : drc_pin_ctrl

// ---- drc_top.sv ----
// Reference converter control: APB registers, reference selects, pin overrides
//
// What this block does
// - Bit 7 of control A enables converter
// - Level code in level register bits 4-0
// - Output is lower plus span times code/32
// - Bit 5 routes voltage to pin one
// - Bit 4 routes voltage to pin two
// - Decode upper source; code 11 reserved
// - Bit 0 selects external lower reference
// - Driven pin overrides digital driver, pull-up
// - Digital read of driven pin returns zero
// - Settings kept and running through sleep
// - Reset disables converter, pins, clears level
// - Unimplemented bits read as zero
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
module drc_top
   import drc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic             pready_o,
   output logic [31:0]      prdata_o,
   output logic             pslverr_o,
   // Power state
   input  wire logic        sleep_i,
   // Digital pad side, one bit per pin
   input  wire logic [1:0]  pad_in_i,
   input  wire logic [1:0]  gpio_out_i,
   input  wire logic [1:0]  gpio_oe_i,
   input  wire logic [1:0]  pullup_req_i,
   output logic [1:0]       pad_out_o,
   output logic [1:0]       pad_oe_o,
   output logic [1:0]       pullup_en_o,
   output logic [1:0]       gpio_read_o,
   // Analog controls
   output logic             conv_enable_o,
   output logic [1:0]       analog_sw_o,
   output logic [2:0]       upper_sel_o,
   output logic             lower_sel_o,
   output logic [4:0]       level_code_o,
   output logic [5:0]       level_num_o
);

   ////////////////////////////////////////////////////////////////////////
   // Register state

   logic [7:0]  ctrl_a_reg;           // converter_control_a
   logic [7:0]  ctrl_a_next;
   logic [7:0]  level_reg;            // converter_level_select
   logic [7:0]  level_next;
   logic [31:0] rdata_reg;            // Registered read data
   logic [31:0] rdata_next;
   logic        err_reg;              // Registered slave error
   logic        err_next;

   logic        access;               // Access phase of a transfer
   logic        hit_a;                // Address matches control A
   logic        hit_l;                // Address matches level register
   logic        wr_ok;                // Write access with byte lane 0 strobed, any address

   // Slave answers in the first access cycle, no wait states
   assign pready_o  = 1'b1;
   assign access    = psel_i & penable_i;
   assign hit_a     = (paddr_i == DRC_OFF_CTRL_A);
   assign hit_l     = (paddr_i == DRC_OFF_LEVEL);
   assign wr_ok     = access & pwrite_i & pstrb_i[0];

   ////////////////////////////////////////////////////////////////////////
   // Next-value logic for registers and read data

   always_comb begin
      ctrl_a_next = ctrl_a_reg;
      level_next  = level_reg;
      rdata_next  = rdata_reg;
      err_next    = 1'b0;
      // Sleep is not an input here: settings hold through it
      if (wr_ok && hit_a) begin
         // Mask keeps unused bits zero
         ctrl_a_next = pwdata_i[7:0] & DRC_MASK_CTRL_A;
      end
      if (wr_ok && hit_l) begin
         level_next = pwdata_i[7:0] & DRC_MASK_LEVEL;
      end
      // Read data taken at setup so it stands through the access phase
      if (psel_i && !penable_i && !pwrite_i) begin
         if (paddr_i == DRC_OFF_CTRL_A) begin
            rdata_next = {24'h000000, ctrl_a_reg};
         end else if (paddr_i == DRC_OFF_LEVEL) begin
            rdata_next = {24'h000000, level_reg};
         end else begin
            rdata_next = 32'h00000000;
         end
      end
      // Unmapped address gets an error
      if (psel_i && !penable_i) begin
         err_next = ~((paddr_i == DRC_OFF_CTRL_A) |
                      (paddr_i == DRC_OFF_LEVEL));
      end
   end

   // Register update; reset clears every setting
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_a_reg <= DRC_RST_CTRL_A;
         level_reg  <= DRC_RST_LEVEL;
         rdata_reg  <= 32'h00000000;
         err_reg    <= 1'b0;
      end else begin
         ctrl_a_reg <= ctrl_a_next;
         level_reg  <= level_next;
         rdata_reg  <= rdata_next;
         err_reg    <= err_next;
      end
   end

   assign prdata_o  = rdata_reg;
   assign pslverr_o = access & err_reg;

   ////////////////////////////////////////////////////////////////////////
   // Analog controls from the stored settings

   logic [1:0] drive_en;              // Per-pin drive enables

   always_comb begin
      conv_enable_o = ctrl_a_reg[DRC_BIT_ENABLE];
      drive_en[0]   = ctrl_a_reg[DRC_BIT_PIN_ONE];
      drive_en[1]   = ctrl_a_reg[DRC_BIT_PIN_TWO];
      // Reserved code selects nothing rather than a live source
      upper_sel_o   = drc_upper_onehot(
                         ctrl_a_reg[DRC_BIT_UPPER_HI:DRC_BIT_UPPER_LO]);
      lower_sel_o   = ctrl_a_reg[DRC_BIT_LOWER];
      level_code_o  = level_reg[DRC_LEVEL_W-1:0];
      // Tap number out of 32: Vout = Vlow + (Vhigh-Vlow)*tap/32
      level_num_o   = {1'b0, level_reg[DRC_LEVEL_W-1:0]};
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin override instances

   for (genvar p = 0; p < 2; p++) begin : g_pin
      drc_pin_ctrl u_pin (
         .drive_en_i   (drive_en[p]),
         .pad_in_i     (pad_in_i[p]),
         .gpio_out_i   (gpio_out_i[p]),
         .gpio_oe_i    (gpio_oe_i[p]),
         .pullup_req_i (pullup_req_i[p]),
         .analog_sw_o  (analog_sw_o[p]),
         .pad_out_o    (pad_out_o[p]),
         .pad_oe_o     (pad_oe_o[p]),
         .pullup_en_o  (pullup_en_o[p]),
         .gpio_read_o  (gpio_read_o[p])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   // Enable bit follows the last write to control A
   AST_ENABLE: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (wr_ok && hit_a) |=> conv_enable_o == $past(pwdata_i[7]))
      else $error("enable bit not taken from write");

   // Level code follows the last write to the level register
   AST_LEVEL: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (wr_ok && hit_l) |=> level_code_o == $past(pwdata_i[4:0]))
      else $error("level code not taken from write");

   // Tap number follows the written code, top bit always clear
   AST_NUM: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (wr_ok && hit_l) |=> level_num_o == {1'b0, $past(pwdata_i[4:0])})
      else $error("level number not taken from write");

   // Pin one switch follows bit 5 of the write
   AST_PIN1: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (wr_ok && hit_a) |=> analog_sw_o[0] == $past(pwdata_i[5]))
      else $error("pin one switch wrong");

   // Pin two switch follows bit 4 of the write
   AST_PIN2: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (wr_ok && hit_a) |=> analog_sw_o[1] == $past(pwdata_i[4]))
      else $error("pin two switch wrong");

   // At most one source, and the fixed source only for its code
   AST_UPPER: assert property (@(posedge clk_i) disable iff (!resetn_i)
      $countones(upper_sel_o) <= 1 &&
      (ctrl_a_reg[3:2] == 2'h2) == upper_sel_o[2])
      else $error("upper source decode wrong");

   // Lower source follows bit 0 of the write
   AST_LOWER: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (wr_ok && hit_a) |=> lower_sel_o == $past(pwdata_i[0]))
      else $error("lower source select wrong");

   // Driven pin loses its digital driver and pull-up
   AST_OVR: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (analog_sw_o[0] |-> !pad_oe_o[0] && !pullup_en_o[0]) and
      (analog_sw_o[1] |-> !pad_oe_o[1] && !pullup_en_o[1]))
      else $error("digital driver not overridden");

   // Digital read of a driven pin is always zero
   AST_READ0: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (analog_sw_o[0] |-> !gpio_read_o[0]) and
      (analog_sw_o[1] |-> !gpio_read_o[1]))
      else $error("digital read of analog pin not zero");

   // Sleep alone never changes control A
   AST_SLEEP: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (sleep_i && !wr_ok) |=> $stable(ctrl_a_reg))
      else $error("settings changed in sleep");

   // Unimplemented bits can never be stored
   AST_RESV: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ctrl_a_reg[6] == 1'b0 && ctrl_a_reg[1] == 1'b0 &&
      level_reg[7:5] == 3'h0)
      else $error("unimplemented bit set");

   // Level register moves only on a write
   AST_HOLD: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !wr_ok |=> $stable(level_reg) ##1 1'b1)
      else $error("level changed without write");

   // Reset leaves converter off, pins free, level zero
   AST_RST: assert property (@(posedge clk_i)
      $rose(resetn_i) |-> !conv_enable_o && analog_sw_o == 2'h0 &&
      level_code_o == 5'h00)
      else $error("reset state wrong");

   // A write with byte lane 0 low is dropped, no error at a mapped address
   AST_STRB: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (access && pwrite_i && !pstrb_i[0]) |=>
      $stable(ctrl_a_reg) && $stable(level_reg))
      else $error("write with lane 0 low took effect");

   // Writes to unmapped places leave both settings alone
   AST_UNMAP: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (access && pwrite_i && !hit_a && !hit_l) |=>
      $stable(ctrl_a_reg) && $stable(level_reg))
      else $error("unmapped write changed a setting");

   // Error flag stands through the access phase of an unmapped transfer
   AST_ERR: assert property (@(posedge clk_i) disable iff (!resetn_i)
      access |-> pslverr_o == !(hit_a || hit_l))
      else $error("slave error flag wrong");

   // Upper read bits are never driven
   AST_RD_HI: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (access && !pwrite_i) |-> prdata_o[31:8] == 24'h000000)
      else $error("upper read data not zero");

   // Read data is the register as it stood at the setup edge
   AST_RD_A: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (psel_i && !penable_i && !pwrite_i && hit_a) |=>
      prdata_o[7:0] == $past(ctrl_a_reg))
      else $error("control A read data wrong");

   // Same for the level register
   AST_RD_L: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (psel_i && !penable_i && !pwrite_i && hit_l) |=>
      prdata_o[7:0] == $past(level_reg))
      else $error("level read data wrong");

   // Waking leaves control A as it was
   AST_WAKE: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ($fell(sleep_i) && !wr_ok) |=> $stable(ctrl_a_reg))
      else $error("control A changed on wake");

   // Supply and external pin selects follow their codes
   AST_UPSEL: assert property (@(posedge clk_i) disable iff (!resetn_i)
      upper_sel_o[0] == (ctrl_a_reg[3:2] == 2'h0) &&
      upper_sel_o[1] == (ctrl_a_reg[3:2] == 2'h1))
      else $error("supply or pin select wrong");

   // A driven pin also forces its digital output value low
   AST_PADOUT: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (analog_sw_o[0] |-> !pad_out_o[0]) and
      (analog_sw_o[1] |-> !pad_out_o[1]))
      else $error("digital output value not overridden");

   // An undriven pin keeps its full digital function
   AST_PASS: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (!analog_sw_o[0] |-> pad_oe_o[0] == gpio_oe_i[0] &&
       gpio_read_o[0] == pad_in_i[0]) and
      (!analog_sw_o[1] |-> pad_oe_o[1] == gpio_oe_i[1] &&
       gpio_read_o[1] == pad_in_i[1]))
      else $error("digital function of idle pin lost");

   // Cover points for the main scenarios
   COV_EN_WRITE: cover property (@(posedge clk_i) disable iff (!resetn_i)
      wr_ok && hit_a && pwdata_i[7]);
   COV_BOTH_PINS: cover property (@(posedge clk_i) disable iff (!resetn_i)
      analog_sw_o == 2'h3);
   COV_FULL_LEVEL: cover property (@(posedge clk_i) disable iff (!resetn_i)
      level_code_o == 5'h1f);
   COV_BAD_ADDR: cover property (@(posedge clk_i) disable iff (!resetn_i)
      pslverr_o);
   COV_SLEEP_ON: cover property (@(posedge clk_i) disable iff (!resetn_i)
      sleep_i && conv_enable_o);

endmodule : drc_top

// ---- drc_top_tb.sv ----
// Self-checking testbench for the reference converter control block
`timescale 1ns/1ps
module drc_top_tb
   import drc_pkg::*;
;
   ////////////////////////////////////////////////////////////////////////
   // Design ports
   logic        clk_i = 1'b0;          // 20 MHz clock
   logic        resetn_i = 1'b0;       // Async reset, active low
   logic        psel_i = 1'b0;         // APB select
   logic        penable_i = 1'b0;      // APB access phase
   logic        pwrite_i = 1'b0;       // APB direction
   logic [11:0] paddr_i = 12'h000;     // APB byte address
   logic [31:0] pwdata_i = 32'h0;      // APB write data
   logic [3:0]  pstrb_i = 4'h0;        // APB byte strobes
   logic        sleep_i = 1'b0;        // Power state
   logic [1:0]  pad_in_i = 2'h0;       // Raw pad inputs
   logic [1:0]  gpio_out_i = 2'h0;     // Port output values
   logic [1:0]  gpio_oe_i = 2'h0;      // Port output enables
   logic [1:0]  pullup_req_i = 2'h0;   // Port pull-up requests
   logic        pready_o, pslverr_o, conv_enable_o, lower_sel_o;
   logic [31:0] prdata_o;
   logic [1:0]  pad_out_o, pad_oe_o, pullup_en_o, gpio_read_o, analog_sw_o;
   logic [2:0]  upper_sel_o;
   logic [4:0]  level_code_o;
   logic [5:0]  level_num_o;
   // Expected result of one transfer, with register snapshot
   typedef struct packed {
      logic        rd;
      logic        err;
      logic [31:0] data;
      logic [7:0]  ca;
      logic [7:0]  lv;
   } drc_exp_t;
   drc_exp_t    q[$];                  // Notes from driver to monitor
   drc_exp_t    e;                     // Note under comparison
   logic [7:0]  ca_m = 8'h00;          // Model of control A
   logic [7:0]  lv_m = 8'h00;          // Model of level register
   logic [31:0] r;                     // Random word
   logic [1:0]  sw;                    // Expected analog switches
   int          error_cnt = 0;
   int          samples_checked = 0;

   always #25 clk_i = ~clk_i;

   drc_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pready_o(pready_o),
      .prdata_o(prdata_o), .pslverr_o(pslverr_o), .sleep_i(sleep_i),
      .pad_in_i(pad_in_i), .gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i),
      .pullup_req_i(pullup_req_i), .pad_out_o(pad_out_o),
      .pad_oe_o(pad_oe_o), .pullup_en_o(pullup_en_o),
      .gpio_read_o(gpio_read_o), .conv_enable_o(conv_enable_o),
      .analog_sw_o(analog_sw_o), .upper_sel_o(upper_sel_o),
      .lower_sel_o(lower_sel_o), .level_code_o(level_code_o),
      .level_num_o(level_num_o));

   ////////////////////////////////////////////////////////////////////////
   // Verdict and run end, shared with the watchdog
   task stop_test;
      $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : stop_test

   // One comparison; four-state outcome counts as a miss
   task chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("Error at %0t: %s", $time, m);
      end
   endtask : chk

   // APB transfer; notes the expectation, waits bounded for pready
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s);
      logic [7:0] r8;
      logic       hit;
      int         n;
      drc_exp_t   nt;                  // Note for this transfer
      r8 = 8'($urandom);
      hit = (a === DRC_OFF_CTRL_A) || (a === DRC_OFF_LEVEL);
      nt.rd = !wr;
      nt.err = !hit;
      nt.data = !hit ? 32'h0 : {24'h0, (a === DRC_OFF_LEVEL) ? lv_m : ca_m};
      nt.ca = ca_m;
      nt.lv = lv_m;
      q.push_back(nt);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      pstrb_i <= s;
      // Pad side changes with each transfer to stir the overrides
      {pad_in_i, gpio_out_i, gpio_oe_i, pullup_req_i} <= r8;
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (n >= 20) chk(1'b0, "no pready");
      // Write lands on the completing edge only
      if (wr && hit && s[0] && a === DRC_OFF_CTRL_A) ca_m = d[7:0] & 8'hbd;
      if (wr && hit && s[0] && a === DRC_OFF_LEVEL) lv_m = d[7:0] & 8'h1f;
   endtask : apb

   // Release the bus for one cycle
   task idle;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask : idle

   ////////////////////////////////////////////////////////////////////////
   // Monitor: compares the oldest note at every completed transfer
   always @(posedge clk_i) begin
      if (resetn_i && psel_i && penable_i && pready_o === 1'b1) begin
         if (q.size() == 0) chk(1'b0, "unexpected transfer");
         else begin
            e = q.pop_front();
            sw = {e.ca[4], e.ca[5]};
            chk(pslverr_o === e.err, "error flag");
            chk(!e.rd || prdata_o === e.data, "read data");
            chk(conv_enable_o === e.ca[7], "enable");
            chk(analog_sw_o === sw, "pin switches");
            chk(upper_sel_o === (3'h1 << e.ca[3:2]), "upper select");
            chk(lower_sel_o === e.ca[0], "lower select");
            chk(level_code_o === e.lv[4:0], "level code");
            chk(level_num_o === {1'b0, e.lv[4:0]}, "level tap");
            chk(pad_out_o === (gpio_out_i & ~sw), "pad driver");
            chk(pad_oe_o === (gpio_oe_i & ~sw), "pad enable");
            chk(pullup_en_o === (pullup_req_i & ~sw), "pull-up");
            chk(gpio_read_o === (pad_in_i & ~sw), "digital read");
         end
      end
   end

   // Watchdog, far beyond the 160 or so cycles the tests need
   initial begin
      #(50 * 4000);
      error_cnt++;
      $display("Error at %0t: watchdog expired", $time);
      stop_test();
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      void'($urandom(32'haff1f874));
      repeat (4) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      apb(1'b0, DRC_OFF_CTRL_A, 32'h0, 4'h0);
      apb(1'b0, DRC_OFF_LEVEL, 32'h0, 4'h0);
      idle();
      $display("Test reset values done");
      // Every legal upper code, read back-to-back; 11 is never written
      for (int i = 0; i < 3; i++) begin
         r = $urandom;
         apb(1'b1, DRC_OFF_CTRL_A, {r[31:4], 2'(i), r[1:0]}, 4'hf);
         apb(1'b0, DRC_OFF_CTRL_A, 32'h0, 4'h0);
      end
      idle();
      $display("Test upper codes done");
      // Random fields and strobes; lane 0 low must be ignored
      repeat (24) begin
         r = $urandom;
         if (r[3:2] == 2'h3) r[3] = 1'b0;
         apb(1'b1, r[8] ? DRC_OFF_LEVEL : DRC_OFF_CTRL_A, r, r[12:9]);
         apb(1'b0, r[8] ? DRC_OFF_LEVEL : DRC_OFF_CTRL_A, 32'h0, 4'h0);
      end
      idle();
      $display("Test random settings done");
      // Unmapped places: error, no effect, zero data
      apb(1'b1, 12'h008, $urandom, 4'hf);
      apb(1'b0, 12'h008, 32'h0, 4'h0);
      apb(1'b0, 12'hffc, 32'h0, 4'h0);
      apb(1'b0, DRC_OFF_CTRL_A, 32'h0, 4'h0);
      idle();
      $display("Test unmapped done");
      // Settings kept across sleep entry and wake
      apb(1'b1, DRC_OFF_CTRL_A, 32'h0000_00f7, 4'h1);
      sleep_i <= 1'b1;
      repeat (10) idle();
      apb(1'b0, DRC_OFF_CTRL_A, 32'h0, 4'h0);
      sleep_i <= 1'b0;
      apb(1'b0, DRC_OFF_CTRL_A, 32'h0, 4'h0);
      idle();
      $display("Test sleep done");
      // Reset in mid-run clears settings and pins
      apb(1'b1, DRC_OFF_LEVEL, 32'h0000_001f, 4'hf);
      idle();
      resetn_i <= 1'b0;
      ca_m = 8'h00;
      lv_m = 8'h00;
      repeat (4) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      apb(1'b0, DRC_OFF_CTRL_A, 32'h0, 4'h0);
      apb(1'b0, DRC_OFF_LEVEL, 32'h0, 4'h0);
      idle();
      $display("Test mid-run reset done");
      stop_test();
   end

endmodule : drc_top_tb
